// [rtl/psw_defs.svh]
// register offsets, field positions, encodings and timing counts of the power-state block
`ifndef PSW_DEFS_SVH
`define PSW_DEFS_SVH

// device side link word addresses
`define PSW_ADDR_PROBE      8'h64
`define PSW_ADDR_IRQ_STATUS 8'h58
`define PSW_ADDR_INT_EN     8'h5c
`define PSW_ADDR_PMC        8'h84
`define PSW_ADDR_PHY        8'ha0

// power_mgmt_control fields
`define PSW_PMC_READY       0
`define PSW_PMC_PIN_EN      1
`define PSW_PMC_PULSE_SEL   2
`define PSW_PMC_SRC_LO      4
`define PSW_PMC_WF_EN       9
`define PSW_PMC_PSS_LO      12
`define PSW_PMC_ENERGY_EN   14

// interrupt status / enable: wake interrupt bit
`define PSW_INT_WAKE        22

// phy control word fields
`define PSW_PHY_EFLAG       1
`define PSW_PHY_GPD         11
`define PSW_PHY_EDPD        13

// power_state_select encodings and wake_event_source codes
`define PSW_PSS_FULL        2'h0
`define PSW_PSS_WOL         2'h1
`define PSW_PSS_ED          2'h2
`define PSW_SRC_NONE        2'h0
`define PSW_SRC_ENERGY      2'h1
`define PSW_SRC_FRAME       2'h2

// probe register read value, arbitrary
`define PSW_PROBE_VAL       32'h5a5a_0f0f

// timing
`define PSW_CLK_MHZ         100
`define PSW_PULSE_MS        50
`define PSW_READY_MS        2
`define PSW_PULSE_CYC       (`PSW_PULSE_MS * 1000 * `PSW_CLK_MHZ)
`define PSW_READY_CYC       (`PSW_READY_MS * 1000 * `PSW_CLK_MHZ)

// host side avalon byte offsets
`define PSW_AV_CMD          4'h0
`define PSW_AV_WDATA        4'h4
`define PSW_AV_RDATA        4'h8
`define PSW_AV_STATUS       4'hc
`define PSW_AV_CMD_WR       8
`define PSW_AV_ST_BUSY      0
`define PSW_AV_ST_ERR       1
`define PSW_AV_ST_READY     2

`endif

// [rtl/psw_device.sv]
// power-state and wake controller: the device end of the host link
// Summary of operation
// - writing 01 selects wake-on-LAN sleep
// - writing 10 selects energy-detect sleep
// - ready cleared in sleep until full power
// - wol sleep keeps phy, clock, rx-pm clocks
// - energy sleep stops mac, host, internal, rx-pm clocks
// - host reads only control register while unready
// - host writes only wake probe while unready
// - probe write wakes, select returns to full
// - writes ignored until a read after wake
// - wol sleep detects frames, source becomes 10
// - frame wake drives pin with both enables
// - host programs filters and enables before sleep
// - carrier wakes energy sleep, source becomes 01
// - wake event sets interrupt status bit
// - status held while request, then write-1 clears
// - pulse select 1 gives 50 ms pin pulse
// - pulse select 0 holds pin steadily
// - clearing source or enables drops pin
// - host sets phy energy powerdown bit before energy sleep
// - host clears phy bit only after ready
// - phy general power-down, reset on clear
// - energy powerdown, flag raised on energy
// - ready within 2 ms after probe write
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "psw_defs.svh"
module psw_device
    import psw_pkg::*;
#(
    parameter int unsigned PULSE_CYC = `PSW_PULSE_CYC,
    parameter int unsigned READY_CYC = `PSW_READY_CYC
) (
    input  wire logic  clk_i,
    input  wire logic  rst_n_i,
    psw_link_if.dev    link,
    input  wire logic  wake_frame_i,
    input  wire logic  wake_pattern_i,
    input  wire logic  line_energy_present_i,
    output logic       wake_pin_o,
    output logic       irq_o,
    output logic       clk_en_mac_o,
    output logic       clk_en_host_o,
    output logic       clk_en_phy_o,
    output logic       clk_en_int_o,
    output logic       clk_en_rxpm_o,
    output logic       phy_powered_o,
    output logic       phy_reset_o
);

    localparam logic [22:0] PULSE_LD = 23'(PULSE_CYC);
    localparam logic [22:0] READY_LD = 23'(READY_CYC);

    // reset walks through the resume wait so ready rises like after a wake
    localparam psw_dev_t RST_VAL = '{
        st: PSW_RESUME, ready_cnt: READY_LD,
        en_mac: 1'b1, en_host: 1'b1, en_phy: 1'b1, en_int: 1'b1, en_rxpm: 1'b1,
        phy_pwr: 1'b1, default: '0};

    psw_dev_t s_ff;
    psw_dev_t nxt_s;
    logic     wake_req;
    logic     wr_ok;

    function automatic logic [31:0] pmc_word(input psw_dev_t d);
        logic [31:0] w;
        w = '0;
        w[`PSW_PMC_READY]     = d.ready;
        w[`PSW_PMC_PIN_EN]    = d.pin_en;
        w[`PSW_PMC_PULSE_SEL] = d.pulse_sel;
        w[`PSW_PMC_SRC_LO+:2] = d.src;
        w[`PSW_PMC_WF_EN]     = d.wf_en;
        w[`PSW_PMC_ENERGY_EN]  = d.energy_wake_en;
        unique case (d.st)
            PSW_WOL: w[`PSW_PMC_PSS_LO+:2] = `PSW_PSS_WOL;
            PSW_ED:  w[`PSW_PMC_PSS_LO+:2] = `PSW_PSS_ED;
            PSW_FULL,
            PSW_RESUME: w[`PSW_PMC_PSS_LO+:2] = `PSW_PSS_FULL;
        endcase
        return w;
    endfunction : pmc_word

    always_comb begin
        nxt_s         = s_ff;
        nxt_s.ack     = 1'b0;
        nxt_s.phy_rst = 1'b0;
        // a wake request lives as long as the source and its matching enable
        wake_req = (s_ff.src == `PSW_SRC_FRAME && s_ff.wf_en)
                || (s_ff.src == `PSW_SRC_ENERGY && s_ff.energy_wake_en);
        wr_ok = s_ff.rd_seen && s_ff.ready;

        if (link.rd_req) begin
            nxt_s.ack     = 1'b1;
            nxt_s.rd_seen = 1'b1;
            nxt_s.rdata   = '0;
            // while unready only the control register answers
            if (link.addr == `PSW_ADDR_PMC) begin
                nxt_s.rdata = pmc_word(s_ff);
            end else if (s_ff.ready) begin
                unique case (link.addr)
                    `PSW_ADDR_PROBE:   nxt_s.rdata = `PSW_PROBE_VAL;
                    `PSW_ADDR_IRQ_STATUS: nxt_s.rdata[`PSW_INT_WAKE] = s_ff.wake_sts;
                    `PSW_ADDR_INT_EN:  nxt_s.rdata[`PSW_INT_WAKE] = s_ff.int_en;
                    `PSW_ADDR_PHY: begin
                        nxt_s.rdata[`PSW_PHY_GPD]   = s_ff.phy_gpd;
                        nxt_s.rdata[`PSW_PHY_EDPD]  = s_ff.phy_edpd;
                        nxt_s.rdata[`PSW_PHY_EFLAG] = s_ff.phy_eflag;
                    end
                    default: nxt_s.rdata = '0;
                endcase
            end
        end

        if (link.wr_req) begin
            nxt_s.ack = 1'b1;
            if ((s_ff.st == PSW_WOL || s_ff.st == PSW_ED)
                    && link.addr == `PSW_ADDR_PROBE) begin
                // any data wakes; select field now reads full power
                nxt_s.st        = PSW_RESUME;
                nxt_s.ready_cnt = READY_LD;
                nxt_s.rd_seen   = 1'b0;
            end else if (s_ff.st == PSW_FULL && wr_ok) begin
                unique case (link.addr)
                    `PSW_ADDR_PMC: begin
                        nxt_s.pin_en    = link.wdata[`PSW_PMC_PIN_EN];
                        nxt_s.pulse_sel = link.wdata[`PSW_PMC_PULSE_SEL];
                        nxt_s.src       = link.wdata[`PSW_PMC_SRC_LO+:2];
                        nxt_s.wf_en     = link.wdata[`PSW_PMC_WF_EN];
                        nxt_s.energy_wake_en = link.wdata[`PSW_PMC_ENERGY_EN];
                        if (link.wdata[`PSW_PMC_PSS_LO+:2] == `PSW_PSS_WOL) begin
                            nxt_s.st    = PSW_WOL;
                            nxt_s.ready = 1'b0;
                        end else if (link.wdata[`PSW_PMC_PSS_LO+:2] == `PSW_PSS_ED) begin
                            nxt_s.st    = PSW_ED;
                            nxt_s.ready = 1'b0;
                        end
                    end
                    `PSW_ADDR_IRQ_STATUS: begin
                        if (link.wdata[`PSW_INT_WAKE]) begin
                            nxt_s.wake_sts = 1'b0;
                        end
                    end
                    `PSW_ADDR_INT_EN: nxt_s.int_en = link.wdata[`PSW_INT_WAKE];
                    `PSW_ADDR_PHY: begin
                        nxt_s.phy_gpd  = link.wdata[`PSW_PHY_GPD];
                        nxt_s.phy_edpd = link.wdata[`PSW_PHY_EDPD];
                        if (link.wdata[`PSW_PHY_EFLAG]) begin
                            nxt_s.phy_eflag = 1'b0;
                        end
                        if (s_ff.phy_gpd && !link.wdata[`PSW_PHY_GPD]) begin
                            nxt_s.phy_rst = 1'b1;
                        end
                    end
                    default: nxt_s.ack = 1'b1;
                endcase
            end
        end

        // hardware sets come last so they win over a clear in the same cycle
        if (s_ff.st == PSW_WOL && (wake_frame_i || wake_pattern_i)) begin
            nxt_s.src = `PSW_SRC_FRAME;
        end
        // a level, so carrier already present at entry is caught at once
        if (s_ff.st == PSW_ED && line_energy_present_i) begin
            nxt_s.src = `PSW_SRC_ENERGY;
        end
        if (wake_req) begin
            nxt_s.wake_sts = 1'b1;
        end

        nxt_s.req_q = wake_req;
        if (wake_req && !s_ff.req_q) begin
            nxt_s.pulse_cnt = PULSE_LD;
        end else if (s_ff.pulse_cnt != 23'h0) begin
            nxt_s.pulse_cnt = s_ff.pulse_cnt - 23'h1;
        end
        nxt_s.pin = wake_req && s_ff.pin_en
                 && (!s_ff.pulse_sel || nxt_s.pulse_cnt != 23'h0);

        nxt_s.energy_q = line_energy_present_i;
        if (s_ff.phy_edpd && line_energy_present_i && !s_ff.energy_q) begin
            nxt_s.phy_eflag = 1'b1;
        end

        if (s_ff.st == PSW_RESUME) begin
            // clocks are already back; count out the settling time
            if (s_ff.ready_cnt <= 23'h1) begin
                nxt_s.st    = PSW_FULL;
                nxt_s.ready = 1'b1;
            end else begin
                nxt_s.ready_cnt = s_ff.ready_cnt - 23'h1;
            end
        end

        nxt_s.irq     = nxt_s.wake_sts && nxt_s.int_en;
        nxt_s.en_mac  = nxt_s.st == PSW_FULL || nxt_s.st == PSW_RESUME;
        nxt_s.en_host = nxt_s.en_mac;
        nxt_s.en_int  = nxt_s.st != PSW_ED;
        nxt_s.en_rxpm = nxt_s.st != PSW_ED;
        nxt_s.en_phy  = 1'b1;
        // management interface stays up; only the analog side sleeps
        nxt_s.phy_pwr = !nxt_s.phy_gpd
                     && !(nxt_s.phy_edpd && !line_energy_present_i);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_ff <= RST_VAL;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign link.ack      = s_ff.ack;
    assign link.rdata    = s_ff.rdata;
    assign wake_pin_o    = s_ff.pin;
    assign irq_o         = s_ff.irq;
    assign clk_en_mac_o  = s_ff.en_mac;
    assign clk_en_host_o = s_ff.en_host;
    assign clk_en_phy_o  = s_ff.en_phy;
    assign clk_en_int_o  = s_ff.en_int;
    assign clk_en_rxpm_o = s_ff.en_rxpm;
    assign phy_powered_o = s_ff.phy_pwr;
    assign phy_reset_o   = s_ff.phy_rst;

endmodule : psw_device

// [rtl/psw_host.sv]
// host end: avalon-mm command registers driving the power-state link
`timescale 1ns/1ns
`include "psw_defs.svh"
module psw_host
    import psw_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    psw_link_if.hst          link
);

    localparam psw_hst_t RST_VAL = '{wreq: 1'b1, default: '0};

    psw_hst_t s_ff;
    psw_hst_t nxt_s;
    logic     legal;
    logic     pss_sleep;

    always_comb begin
        nxt_s       = s_ff;
        nxt_s.wreq  = 1'b1;
        nxt_s.lk_rd = 1'b0;
        nxt_s.lk_wr = 1'b0;
        // while ready is not known set only control reads and probe writes pass
        legal = s_ff.ready_known
             || (!avs_writedata_i[`PSW_AV_CMD_WR] && avs_writedata_i[7:0] == `PSW_ADDR_PMC)
             || (avs_writedata_i[`PSW_AV_CMD_WR]
                 && avs_writedata_i[7:0] == `PSW_ADDR_PROBE);
        pss_sleep = avs_writedata_i[`PSW_AV_CMD_WR] && avs_writedata_i[7:0] == `PSW_ADDR_PMC
             && s_ff.wdata[`PSW_PMC_PSS_LO+:2] != `PSW_PSS_FULL;
        // energy sleep only once the phy powerdown bit is known set
        if (pss_sleep && s_ff.wdata[`PSW_PMC_PSS_LO+:2] == `PSW_PSS_ED && !s_ff.edpd_set) begin
            legal = 1'b0;
        end

        if ((avs_read_i || avs_write_i) && s_ff.wreq) begin
            nxt_s.wreq      = 1'b0;
            nxt_s.avs_rdata = '0;
            if (avs_read_i) begin
                unique case (avs_address_i)
                    `PSW_AV_CMD: begin
                        nxt_s.avs_rdata[7:0]            = s_ff.cmd_addr;
                        nxt_s.avs_rdata[`PSW_AV_CMD_WR] = s_ff.cmd_wr;
                    end
                    `PSW_AV_WDATA: nxt_s.avs_rdata = s_ff.wdata;
                    `PSW_AV_RDATA: nxt_s.avs_rdata = s_ff.lrdata;
                    `PSW_AV_STATUS: begin
                        nxt_s.avs_rdata[`PSW_AV_ST_BUSY]  = s_ff.busy;
                        nxt_s.avs_rdata[`PSW_AV_ST_ERR]   = s_ff.err;
                        nxt_s.avs_rdata[`PSW_AV_ST_READY] = s_ff.ready_known;
                    end
                    default: nxt_s.avs_rdata = '0;
                endcase
            end else begin
                unique case (avs_address_i)
                    `PSW_AV_CMD: begin
                        if (s_ff.busy || !legal) begin
                            nxt_s.err = 1'b1;
                        end else begin
                            nxt_s.cmd_addr = avs_writedata_i[7:0];
                            nxt_s.cmd_wr   = avs_writedata_i[`PSW_AV_CMD_WR];
                            nxt_s.busy     = 1'b1;
                            nxt_s.lk_rd    = !avs_writedata_i[`PSW_AV_CMD_WR];
                            nxt_s.lk_wr    = avs_writedata_i[`PSW_AV_CMD_WR];
                            if (pss_sleep) begin
                                nxt_s.ready_known = 1'b0;
                            end
                            if (avs_writedata_i[`PSW_AV_CMD_WR]
                                    && avs_writedata_i[7:0] == `PSW_ADDR_PHY) begin
                                nxt_s.edpd_set = s_ff.wdata[`PSW_PHY_EDPD];
                            end
                        end
                    end
                    `PSW_AV_WDATA: begin
                        if (!s_ff.busy) begin
                            nxt_s.wdata = avs_writedata_i;
                        end
                    end
                    `PSW_AV_STATUS: begin
                        if (avs_writedata_i[`PSW_AV_ST_ERR]) begin
                            nxt_s.err = 1'b0;
                        end
                    end
                    default: nxt_s.err = s_ff.err;
                endcase
            end
        end

        if (s_ff.busy && link.ack) begin
            nxt_s.busy = 1'b0;
            if (!s_ff.cmd_wr) begin
                nxt_s.lrdata = link.rdata;
                if (s_ff.cmd_addr == `PSW_ADDR_PMC) begin
                    nxt_s.ready_known = link.rdata[`PSW_PMC_READY];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_ff <= RST_VAL;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign avs_readdata_o    = s_ff.avs_rdata;
    assign avs_waitrequest_o = s_ff.wreq;
    assign link.rd_req       = s_ff.lk_rd;
    assign link.wr_req       = s_ff.lk_wr;
    assign link.addr         = s_ff.cmd_addr;
    assign link.wdata        = s_ff.wdata;

endmodule : psw_host

// [rtl/psw_link_if.sv]
// link between the host bus master and the power-state device
`timescale 1ns/1ns
interface psw_link_if;
    logic        rd_req;
    logic        wr_req;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        ack;
    logic [31:0] rdata;

    modport dev (input rd_req, input wr_req, input addr, input wdata, output ack, output rdata);
    modport hst (output rd_req, output wr_req, output addr, output wdata, input ack, input rdata);
endinterface : psw_link_if

// [rtl/psw_pkg.sv]
// types shared by both ends of the power-state link
package psw_pkg;

    typedef enum logic [1:0] {
        PSW_FULL   = 2'b00,
        PSW_WOL    = 2'b01,
        PSW_ED     = 2'b10,
        PSW_RESUME = 2'b11
    } psw_state_t;

    typedef struct packed {
        psw_state_t  st;
        logic        ready;
        logic        rd_seen;
        logic        pin_en;
        logic        pulse_sel;
        logic [1:0]  src;
        logic        wf_en;
        logic        energy_wake_en;
        logic        wake_sts;
        logic        int_en;
        logic        phy_gpd;
        logic        phy_edpd;
        logic        phy_eflag;
        logic        energy_q;
        logic        req_q;
        logic        pin;
        logic [22:0] pulse_cnt;
        logic [22:0] ready_cnt;
        logic        ack;
        logic [31:0] rdata;
        logic        irq;
        logic        en_mac;
        logic        en_host;
        logic        en_phy;
        logic        en_int;
        logic        en_rxpm;
        logic        phy_pwr;
        logic        phy_rst;
    } psw_dev_t;

    typedef struct packed {
        logic        wreq;
        logic [31:0] avs_rdata;
        logic        busy;
        logic        err;
        logic [7:0]  cmd_addr;
        logic        cmd_wr;
        logic [31:0] wdata;
        logic [31:0] lrdata;
        logic        lk_rd;
        logic        lk_wr;
        logic        ready_known;
        logic        edpd_set;
    } psw_hst_t;

endpackage : psw_pkg

// [testbench/power_state_wake_control_tb.sv]
// self-checking bench for both ends of the power-state link
`timescale 1ns/1ns
`include "psw_defs.svh"
module power_state_wake_control_tb;
    localparam int unsigned PULSE = 20;
    localparam logic [31:0] M     = 32'h7237;
    localparam logic [31:0] WI    = 32'h0040_0000;
    logic        clk_i;
    logic        rst_n_i;
    logic [3:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        wake_frame_i;
    logic        wake_pattern_i;
    logic        line_energy_present_i;
    logic        wake_pin_o;
    logic        irq_o;
    logic [4:0]  clk_en;
    logic        phy_powered_o;
    logic        phy_reset_o;
    logic [31:0] q;
    int          num_errors;
    int          compares;
    int          resets_seen;

    psw_link_if lk();
    psw_host psw_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .link(lk));
    // short counts keep the run brief
    psw_device #(.PULSE_CYC(PULSE), .READY_CYC(10)) psw_device_i (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .link(lk), .wake_frame_i(wake_frame_i),
        .wake_pattern_i(wake_pattern_i), .line_energy_present_i(line_energy_present_i),
        .wake_pin_o(wake_pin_o), .irq_o(irq_o), .clk_en_mac_o(clk_en[4]),
        .clk_en_host_o(clk_en[3]), .clk_en_phy_o(clk_en[2]), .clk_en_int_o(clk_en[1]),
        .clk_en_rxpm_o(clk_en[0]), .phy_powered_o(phy_powered_o), .phy_reset_o(phy_reset_o));
    psw_link_checker psw_link_checker_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .rd_req(lk.rd_req), .wr_req(lk.wr_req), .addr(lk.addr), .wdata(lk.wdata),
        .ack(lk.ack), .rdata(lk.rdata));

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (phy_reset_o === 1'b1) resets_seen++;

    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // entered just after a rising edge; holds the request until waitrequest low
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        avs_address_i   <= a;
        avs_write_i     <= w;
        avs_read_i      <= !w;
        avs_writedata_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) num_errors++;
        r = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask : av

    task automatic lk_op(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] r);
        logic [31:0] s;
        int n;
        n = 0;
        av(1'b1, `PSW_AV_WDATA, d, s);
        av(1'b1, `PSW_AV_CMD, {23'h0, w, a}, s);
        do begin
            av(1'b0, `PSW_AV_STATUS, 32'h0, s);
            n++;
        end while (s[`PSW_AV_ST_BUSY] !== 1'b0 && n < 20);
        check("link status", {30'h0, s[`PSW_AV_ST_ERR], s[`PSW_AV_ST_BUSY]}, 32'h0);
        av(1'b0, `PSW_AV_RDATA, 32'h0, r);
    endtask : lk_op

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            lk_op(1'b0, `PSW_ADDR_PMC, 32'h0, q);
            n++;
        end while (q[0] !== 1'b1 && n < 20);
        check("ready polls", {31'h0, n <= 3}, 32'h1);
    endtask : wait_ready

    task automatic t_wol();
        lk_op(1'b1, `PSW_ADDR_INT_EN, WI, q);
        wake_frame_i <= 1'b1;
        @(posedge clk_i);
        wake_frame_i <= 1'b0;
        lk_op(1'b1, `PSW_ADDR_PMC, 32'h1202, q);
        lk_op(1'b0, `PSW_ADDR_PMC, 32'h0, q);
        check("pm wol", q & M, 32'h1202);
        check("clk wol", {27'h0, clk_en}, 32'h07);
        wake_pattern_i <= 1'b1;
        @(posedge clk_i);
        wake_pattern_i <= 1'b0;
        lk_op(1'b0, `PSW_ADDR_PMC, 32'h0, q);
        check("pm frame", q & M, 32'h1222);
        check("pin level", {31'h0, wake_pin_o}, 32'h1);
        lk_op(1'b1, `PSW_ADDR_PROBE, 32'h0, q);
        wait_ready();
        check("pm woke", q & M, 32'h0223);
        check("clk woke", {27'h0, clk_en}, 32'h1f);
        check("irq", {31'h0, irq_o}, 32'h1);
        // request still active, so the clear must not take
        lk_op(1'b1, `PSW_ADDR_IRQ_STATUS, WI, q);
        lk_op(1'b0, `PSW_ADDR_IRQ_STATUS, 32'h0, q);
        check("sts held", q & WI, WI);
        lk_op(1'b1, `PSW_ADDR_PMC, 32'h0202, q);
        check("pin off", {31'h0, wake_pin_o}, 32'h0);
        lk_op(1'b1, `PSW_ADDR_IRQ_STATUS, WI, q);
        lk_op(1'b0, `PSW_ADDR_IRQ_STATUS, 32'h0, q);
        check("sts clr", q & WI, 32'h0);
        check("irq off", {31'h0, irq_o}, 32'h0);
    endtask : t_wol

    task automatic t_ed();
        int n;
        n = 0;
        lk_op(1'b1, `PSW_ADDR_PHY, 32'h2000, q);
        lk_op(1'b1, `PSW_ADDR_PMC, 32'h6006, q);
        lk_op(1'b0, `PSW_ADDR_PMC, 32'h0, q);
        check("pm ed", q & M, 32'h6006);
        check("clk ed", {27'h0, clk_en}, 32'h04);
        check("phy off", {31'h0, phy_powered_o}, 32'h0);
        line_energy_present_i <= 1'b1;
        while (wake_pin_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        while (wake_pin_o === 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        check("pulse len", n, PULSE);
        lk_op(1'b0, `PSW_ADDR_PMC, 32'h0, q);
        check("pm energy", q & M, 32'h6016);
        check("phy on", {31'h0, phy_powered_o}, 32'h1);
        lk_op(1'b1, `PSW_ADDR_PROBE, 32'h0, q);
        wait_ready();
        check("pm ed woke", q & M, 32'h4017);
        lk_op(1'b0, `PSW_ADDR_PHY, 32'h0, q);
        check("phy flag", q & 32'h2802, 32'h2002);
        lk_op(1'b1, `PSW_ADDR_PHY, 32'h0, q);
        lk_op(1'b1, `PSW_ADDR_PMC, 32'h4006, q);
        lk_op(1'b1, `PSW_ADDR_IRQ_STATUS, WI, q);
        check("irq ed off", {31'h0, irq_o}, 32'h0);
        line_energy_present_i <= 1'b0;
    endtask : t_ed

    task automatic t_gpd();
        resets_seen = 0;
        lk_op(1'b1, `PSW_ADDR_PHY, 32'h0800, q);
        check("gpd off", {31'h0, phy_powered_o}, 32'h0);
        lk_op(1'b1, `PSW_ADDR_PHY, 32'h0, q);
        check("gpd on", {31'h0, phy_powered_o}, 32'h1);
        check("phy resets", resets_seen, 1);
        // once ready, addresses beyond the control register answer too
        lk_op(1'b0, `PSW_ADDR_PROBE, 32'h0, q);
        check("probe word", q, `PSW_PROBE_VAL);
    endtask : t_gpd

    task automatic stop_test();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        clk_i = 1'b0;
        rst_n_i = 1'b0;
        avs_address_i = 4'h0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        wake_frame_i = 1'b0;
        wake_pattern_i = 1'b0;
        line_energy_present_i = 1'b0;
        num_errors = 0;
        compares = 0;
        resets_seen = 0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        wait_ready();
        check("pm boot", q & M, 32'h1);
        t_wol();
        t_ed();
        t_gpd();
        stop_test();
    end

    // far above the few hundred cycles the sequence needs
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end
endmodule : power_state_wake_control_tb

// [testbench/psw_link_checker.sv]
// assertions on the link between the host end and the device end
`timescale 1ns/1ns
`include "psw_defs.svh"
module psw_link_checker (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        rd_req,
    input  wire logic        wr_req,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        ack,
    input  wire logic [31:0] rdata
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_pm_rd;
        rd_req && addr == `PSW_ADDR_PMC ##1 ack;
    endsequence
    sequence s_probe_rd;
        rd_req && addr == `PSW_ADDR_PROBE ##1 ack;
    endsequence

    a_ack_follows: assert property ((rd_req || wr_req) |=> ack)
        else $error("request not answered next cycle");
    a_ack_caused: assert property (ack |-> $past(rd_req || wr_req))
        else $error("answer without request");
    a_ack_lone: assert property (ack |=> !ack)
        else $error("answer longer than one cycle");
    a_req_apart: assert property ((rd_req || wr_req) |=> !(rd_req || wr_req))
        else $error("requests back to back");
    a_req_single: assert property (!(rd_req && wr_req))
        else $error("read and write together");
    a_ready_full: assert property (s_pm_rd |-> !rdata[0] || rdata[13:12] == 2'h0)
        else $error("ready with sleep select");
    a_select_code: assert property (s_pm_rd |-> rdata[13:12] != 2'h3)
        else $error("undefined select code");
    a_probe_word: assert property (s_probe_rd |-> rdata == `PSW_PROBE_VAL || rdata == 0)
        else $error("probe read value wrong");
    a_rdata_hold: assert property (!rd_req |=> $stable(rdata))
        else $error("read data moved without read");
endmodule : psw_link_checker
